//--- scc_pkg.sv
// package: constants, types and register map of the stepper chopper core
package scc_pkg;
    // =========================================================
    // clock and timing
    localparam int CLK_KHZ = 20000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int OSC_KHZ = 1600;
    localparam int OSC_DIV = CLK_KHZ / OSC_KHZ;
    localparam int STEP_HIGH_NS = 300;
    localparam int STEP_LOW_NS = 250;
    localparam int BLANK_NS = 300;
    localparam int STEP_HIGH_CYC = (STEP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_LOW_CYC = (STEP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
    localparam logic [3:0] CHOP_LAST = 4'hf;
    localparam logic [3:0] MIX_FAST_START = 4'hc;
    localparam logic [2:0] OC_BLANK_TICKS = 3'h4;

    // =========================================================
    // register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] STATE_OFS = 8'h0c;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DECAY_LSB = 2;
    localparam int CTRL_ENABLE_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam int EV_OVERCURRENT = 0;
    localparam int EV_THERMAL = 1;
    localparam int EV_STEP = 2;
    localparam logic [2:0] EV_RESET = 3'h0;
    localparam logic [1:0] MODE_STANDBY = 2'h0;

    // =========================================================
    // types
    typedef enum logic [1:0] {DECAY_SLOW, DECAY_FAST, DECAY_MIXED} scc_decay_e;
    typedef enum logic {PH_CHARGE, PH_DECAY} scc_phase_e;
    typedef struct packed {
        logic upper_switch_one;
        logic lower_switch_one;
        logic upper_switch_two;
        logic lower_switch_two;
    } scc_gate_s;
    localparam scc_gate_s GATE_OFF = 4'h0;
endpackage

//--- scc_core.sv
// stepper chopper control core: step filter, chopper, fault latch, registers
`timescale 1ns/100ps
module scc_core (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESETN,
    // register port
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    output logic O_IRQ,
    // step clock from host
    input wire logic I_STEP_CLK,
    // analog comparators, one bit per channel; thermal is a single bit
    input wire logic [1:0] I_SENSE_PEAK,
    input wire logic [1:0] I_OVERCURRENT,
    input wire logic I_THERMAL,
    // bridge gates, channel a and b
    output scc_pkg::scc_gate_s O_GATE_A,
    output scc_pkg::scc_gate_s O_GATE_B
);
    // bridge drive for one direction and phase
    function automatic scc_pkg::scc_gate_s gate_of(input logic charge, input logic reverse,
                                                   input logic fast);
        scc_pkg::scc_gate_s g;
        if (charge && !reverse) begin
            g = 4'h9;
        end else if (charge) begin
            g = 4'h6;
        end else if (!fast) begin
            g = 4'h5;
        end else if (!reverse) begin
            g = 4'h6;
        end else begin
            g = 4'h9;
        end
        return g;
    endfunction

    // =========================================================
    // registers
    logic [4:0] ctrl_reg, ctrl_next;
    logic [2:0] status_reg, status_next;
    logic [2:0] mask_reg, mask_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [2:0] events;
    logic fault_reg;
    logic [1:0] angle_reg;
    scc_pkg::scc_phase_e phase_reg [2];
    logic [1:0] mode_sel;
    logic [1:0] decay_sel;
    logic enable;
    logic standby;

    assign mode_sel = ctrl_reg[scc_pkg::CTRL_MODE_LSB +: 2];
    assign decay_sel = ctrl_reg[scc_pkg::CTRL_DECAY_LSB +: 2];
    assign enable = ctrl_reg[scc_pkg::CTRL_ENABLE_BIT];
    assign standby = (mode_sel == scc_pkg::MODE_STANDBY);

    // register writes, sticky events, read mux
    always_comb begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        rdata_next = 32'h0;
        if (I_WR && I_ADDR == scc_pkg::CTRL_OFS) begin
            ctrl_next = I_WDATA[4:0];
        end
        if (I_WR && I_ADDR == scc_pkg::MASK_OFS) begin
            mask_next = I_WDATA[2:0];
        end
        if (I_WR && I_ADDR == scc_pkg::STATUS_OFS) begin
            status_next = status_reg & ~I_WDATA[2:0];
        end
        status_next = status_next | events; // set wins over clear
        if (I_RD) begin
            case (I_ADDR)
                scc_pkg::CTRL_OFS: rdata_next = {27'h0, ctrl_reg};
                scc_pkg::STATUS_OFS: rdata_next = {29'h0, status_reg};
                scc_pkg::MASK_OFS: rdata_next = {29'h0, mask_reg};
                scc_pkg::STATE_OFS: rdata_next = {27'h0, phase_reg[1], phase_reg[0], fault_reg, angle_reg};
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl_reg <= scc_pkg::CTRL_RESET;
            mask_reg <= scc_pkg::EV_RESET;
            status_reg <= scc_pkg::EV_RESET;
            rdata_reg <= 32'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            rdata_reg <= rdata_next;
        end
    end

    assign O_RDATA = rdata_reg;
    assign O_IRQ = |(status_reg & mask_reg);

    // =========================================================
    // step clock synchroniser, pulse filter and angle
    logic step_meta_reg, step_sync_reg;
    logic step_filt_reg, step_filt_next;
    logic [2:0] step_cnt_reg, step_cnt_next;
    logic [1:0] angle_next;
    logic step_event;
    logic [2:0] step_need;

    // a new level is taken only after it held for its least width
    always_comb begin
        step_filt_next = step_filt_reg;
        step_cnt_next = 3'h0;
        angle_next = angle_reg;
        step_event = 1'b0;
        step_need = step_sync_reg ? 3'(scc_pkg::STEP_HIGH_CYC - 1) : 3'(scc_pkg::STEP_LOW_CYC - 1);
        if (step_sync_reg != step_filt_reg) begin
            step_cnt_next = step_cnt_reg + 3'h1;
            if (step_cnt_reg == step_need) begin
                step_filt_next = step_sync_reg;
                step_cnt_next = 3'h0;
                if (step_sync_reg) begin
                    angle_next = angle_reg + 2'h1;
                    step_event = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            step_meta_reg <= 1'b0;
            step_sync_reg <= 1'b0;
            step_filt_reg <= 1'b0;
            step_cnt_reg <= 3'h0;
            angle_reg <= 2'h0;
        end else begin
            step_meta_reg <= I_STEP_CLK;
            step_sync_reg <= step_meta_reg;
            step_filt_reg <= step_filt_next;
            step_cnt_reg <= step_cnt_next;
            angle_reg <= angle_next;
        end
    end

    // =========================================================
    // oscillator tick divider and chop period counter
    logic [3:0] osc_div_reg, osc_div_next;
    logic [3:0] chop_reg, chop_next;
    logic osc_tick;
    logic period_start;

    always_comb begin
        osc_tick = (osc_div_reg == 4'(scc_pkg::OSC_DIV - 1));
        osc_div_next = osc_tick ? 4'h0 : osc_div_reg + 4'h1;
        chop_next = osc_tick ? chop_reg + 4'h1 : chop_reg;
        period_start = osc_tick && (chop_reg == scc_pkg::CHOP_LAST);
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            osc_div_reg <= 4'h0;
            chop_reg <= 4'h0;
        end else begin
            osc_div_reg <= osc_div_next;
            chop_reg <= chop_next;
        end
    end

    // =========================================================
    // fault detection and latch
    logic [2:0] oc_cnt_reg, oc_cnt_next;
    logic fault_next;
    logic oc_trip;

    // over-current must persist through the blank count to trip
    always_comb begin
        oc_cnt_next = 3'h0;
        oc_trip = 1'b0;
        if (|I_OVERCURRENT) begin
            oc_cnt_next = oc_cnt_reg;
            if (osc_tick && oc_cnt_reg != scc_pkg::OC_BLANK_TICKS) begin
                oc_cnt_next = oc_cnt_reg + 3'h1;
            end
            oc_trip = (oc_cnt_reg == scc_pkg::OC_BLANK_TICKS);
        end
        fault_next = fault_reg;
        if (standby) begin
            fault_next = 1'b0;
        end
        if (oc_trip || I_THERMAL) begin
            fault_next = 1'b1;
        end
        events = 3'h0;
        events[scc_pkg::EV_OVERCURRENT] = oc_trip && !fault_reg;
        events[scc_pkg::EV_THERMAL] = I_THERMAL && !fault_reg;
        events[scc_pkg::EV_STEP] = step_event;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            oc_cnt_reg <= 3'h0;
            fault_reg <= 1'b0;
        end else begin
            oc_cnt_reg <= oc_cnt_next;
            fault_reg <= fault_next;
        end
    end

    // =========================================================
    // per channel chopper phase, sense blanking and gates
    scc_pkg::scc_phase_e phase_next [2];
    scc_pkg::scc_gate_s gate_reg [2];
    scc_pkg::scc_gate_s gate_next [2];
    logic [2:0] blank_reg [2];
    logic [2:0] blank_next [2];
    logic [1:0] reverse;
    logic fast;
    logic drive_off;

    // full step sequence gives each channel its current direction
    assign reverse = {angle_reg[1] ^ angle_reg[0], angle_reg[1]};
    assign fast = (decay_sel == scc_pkg::DECAY_FAST) ||
                  (decay_sel == scc_pkg::DECAY_MIXED && chop_reg >= scc_pkg::MIX_FAST_START);
    assign drive_off = fault_reg || fault_next || standby || !enable;

    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            phase_next[ch] = phase_reg[ch];
            case (phase_reg[ch])
                scc_pkg::PH_CHARGE: begin
                    // peak comparator already holds the one fifth scaled reference
                    if (I_SENSE_PEAK[ch] && blank_reg[ch] == 3'h0) begin
                        phase_next[ch] = scc_pkg::PH_DECAY;
                    end
                end
                scc_pkg::PH_DECAY: phase_next[ch] = scc_pkg::PH_DECAY;
                default: phase_next[ch] = scc_pkg::PH_CHARGE;
            endcase
            if (period_start) begin
                phase_next[ch] = scc_pkg::PH_CHARGE;
            end
            if (drive_off) begin
                gate_next[ch] = scc_pkg::GATE_OFF;
            end else begin
                gate_next[ch] = gate_of(phase_next[ch] == scc_pkg::PH_CHARGE, reverse[ch], fast);
            end
            blank_next[ch] = (blank_reg[ch] != 3'h0) ? blank_reg[ch] - 3'h1 : 3'h0;
            if (gate_next[ch] != gate_reg[ch]) begin
                blank_next[ch] = 3'(scc_pkg::BLANK_CYC);
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            for (int ch = 0; ch < 2; ch++) begin
                phase_reg[ch] <= scc_pkg::PH_CHARGE;
                gate_reg[ch] <= scc_pkg::GATE_OFF;
                blank_reg[ch] <= 3'h0;
            end
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                phase_reg[ch] <= phase_next[ch];
                gate_reg[ch] <= gate_next[ch];
                blank_reg[ch] <= blank_next[ch];
            end
        end
    end

    assign O_GATE_A = gate_reg[0];
    assign O_GATE_B = gate_reg[1];
endmodule

//--- scc_checker.sv
// checker: port-level properties of the chopper core
`timescale 1ns/100ps
module scc_checker (
    // watched ports
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic O_IRQ,
    input wire logic [1:0] I_SENSE_PEAK,
    input wire logic [1:0] I_OVERCURRENT,
    input wire logic I_THERMAL,
    input wire scc_pkg::scc_gate_s O_GATE_A,
    input wire scc_pkg::scc_gate_s O_GATE_B
);
    logic [7:0] oc_cnt_reg;
    logic [7:0] oc_cnt_next;
    // counts cycles of unbroken over-current, saturating
    always_comb begin
        oc_cnt_next = 8'h00;
        if (|I_OVERCURRENT) begin
            oc_cnt_next = (oc_cnt_reg == 8'hff) ? oc_cnt_reg : oc_cnt_reg + 8'h01;
        end
    end
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            oc_cnt_reg <= 8'h00;
        end else begin
            oc_cnt_reg <= oc_cnt_next;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    a_gate_legal: assert property (O_GATE_A inside {4'h0, 4'h5, 4'h6, 4'h9}
        && O_GATE_B inside {4'h0, 4'h5, 4'h6, 4'h9}) else $error("illegal gate pattern");
    a_thermal_off: assert property (I_THERMAL |=> O_GATE_A == 4'h0 && O_GATE_B == 4'h0)
        else $error("gates on after thermal fault");
    a_oc_deadline: assert property (oc_cnt_reg > 8'h64 |-> O_GATE_A == 4'h0)
        else $error("over-current shutdown late");
    a_oc_blank: assert property (oc_cnt_reg != 8'h00 && oc_cnt_reg < 8'h1e && $past(O_GATE_A) != 4'h0
        && !$past(I_WR) && !$past(I_WR, 2) && !$past(I_THERMAL) && !I_THERMAL |-> O_GATE_A != 4'h0)
        else $error("over-current acted inside blanking");
    a_latch_hold: assert property ($past(O_GATE_A) == 4'h0 && $past(O_GATE_B) == 4'h0
        && !$past(I_WR) && !$past(I_WR, 2) |-> O_GATE_A == 4'h0) else $error("gates left off state");
    a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0) else $error("read data outside slot");
    a_irq_masked: assert property ($past(I_WR) && $past(I_ADDR) == scc_pkg::MASK_OFS
        && $past(I_WDATA[2:0]) == 3'h0 |-> !O_IRQ) else $error("interrupt with mask clear");
    a_sense_blank: assert property ($changed(O_GATE_A) && O_GATE_A != 4'h0
        |=> (O_GATE_A == 4'h0 || $stable(O_GATE_A))[*4]) else $error("switch inside blank window");
endmodule
bind scc_core scc_checker u_chk (.I_CLK, .I_RESETN, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
    .O_IRQ, .I_SENSE_PEAK, .I_OVERCURRENT, .I_THERMAL, .O_GATE_A, .O_GATE_B);

//--- scc_host_model.sv
// host model: drives the step clock with chosen phase widths
`timescale 1ns/100ps
module scc_host_model (
    // clock and step output
    input wire logic i_clk,
    output logic o_step
);
    initial o_step = 1'b0;
    // one high phase then one low phase, widths in clocks
    task automatic pulse(input int hi, input int lo);
        @(posedge i_clk);
        o_step <= 1'b1;
        repeat (hi) @(posedge i_clk);
        o_step <= 1'b0;
        repeat (lo) @(posedge i_clk);
    endtask
endmodule

//--- scc_core_tb.sv
// testbench: registers, chopper, step filter and fault latch
`timescale 1ns/100ps
module scc_core_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] peak = 2'h0;
    logic [1:0] oc = 2'h0;
    logic hot = 1'b0;
    logic [31:0] rdata;
    logic [31:0] r;
    logic irq;
    logic step;
    scc_pkg::scc_gate_s gate_a;
    scc_pkg::scc_gate_s gate_b;
    int failures = 0;
    int checked = 0;
    time t0;
    // rows: write flag, address, write data, expected read
    logic [72:0] rows [5] = '{{1'b1, 8'h08, 32'h7, 32'h7}, {1'b1, 8'h08, 32'hffffffff, 32'h7},
        {1'b0, 8'h04, 32'h0, 32'h0}, {1'b1, 8'h10, 32'h5, 32'h0}, {1'b1, 8'h00, 32'h4, 32'h4}};
    always #25 clk = ~clk;
    scc_host_model HOST (.i_clk(clk), .o_step(step));
    scc_core DUT (.I_CLK(clk), .I_RESETN(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .O_IRQ(irq), .I_STEP_CLK(step), .I_SENSE_PEAK(peak), .I_OVERCURRENT(oc),
        .I_THERMAL(hot), .O_GATE_A(gate_a), .O_GATE_B(gate_b));
    task automatic summarize;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one strobe cycle; read data taken in the slot after
    task automatic cyc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    task automatic wait_gate(input logic [3:0] g);
        int n;
        n = 0;
        while (gate_a !== g && n < 600) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 600) begin
            failures++;
            summarize();
        end
    endtask
    task automatic edge_set(input logic [1:0] p, input logic [1:0] o, input logic h);
        @(posedge clk);
        peak <= p;
        oc <= o;
        hot <= h;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        #1 chk({23'h0, irq, gate_a, gate_b}, 32'h0);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][72]) cyc(1'b1, rows[i][71:64], rows[i][63:32], r);
            cyc(1'b0, rows[i][71:64], 32'h0, r);
            chk(r, rows[i][31:0]);
        end
        cyc(1'b1, 8'h00, 32'h11, r);
        wait_gate(4'h9);
        chk({28'h0, gate_b}, 32'h9);
        edge_set(2'h3, 2'h0, 1'b0);
        wait_gate(4'h5);
        edge_set(2'h0, 2'h0, 1'b0);
        wait_gate(4'h9);
        t0 = $time;
        edge_set(2'h3, 2'h0, 1'b0);
        wait_gate(4'h5);
        edge_set(2'h0, 2'h0, 1'b0);
        wait_gate(4'h9);
        chk(32'(($time - t0) / 50), 32'(16 * scc_pkg::OSC_DIV));
        cyc(1'b1, 8'h00, 32'h15, r);
        edge_set(2'h3, 2'h0, 1'b0);
        wait_gate(4'h6);
        edge_set(2'h0, 2'h0, 1'b0);
        wait_gate(4'h9);
        HOST.pulse(6, 12);
        cyc(1'b0, 8'h0c, 32'h0, r);
        chk(r & 32'h3, 32'h1);
        HOST.pulse(5, 12);
        cyc(1'b0, 8'h0c, 32'h0, r);
        chk(r & 32'h3, 32'h1);
        HOST.pulse(6, 3);
        HOST.pulse(6, 12);
        cyc(1'b0, 8'h0c, 32'h0, r);
        chk(r & 32'h3, 32'h2);
        wait_gate(4'h6);
        chk({28'h0, gate_b}, 32'h6);
        edge_set(2'h3, 2'h0, 1'b0);
        wait_gate(4'h9);
        chk({31'h0, irq}, 32'h1);
        cyc(1'b1, 8'h08, 32'h0, r);
        chk({31'h0, irq}, 32'h0);
        cyc(1'b1, 8'h08, 32'h4, r);
        cyc(1'b1, 8'h04, 32'h4, r);
        chk({31'h0, irq}, 32'h0);
        edge_set(2'h0, 2'h0, 1'b1);
        edge_set(2'h0, 2'h0, 1'b0);
        repeat (3) @(posedge clk);
        #1 chk({28'h0, gate_a}, 32'h0);
        cyc(1'b0, 8'h04, 32'h0, r);
        chk(r & 32'h2, 32'h2);
        cyc(1'b1, 8'h00, 32'h14, r);
        cyc(1'b1, 8'h00, 32'h15, r);
        wait_gate(4'h6);
        edge_set(2'h0, 2'h1, 1'b0);
        repeat (30) @(posedge clk);
        #1 chk({31'h0, gate_a != 4'h0}, 32'h1);
        repeat (100) @(posedge clk);
        #1 chk({28'h0, gate_a}, 32'h0);
        edge_set(2'h0, 2'h0, 1'b0);
        cyc(1'b0, 8'h04, 32'h0, r);
        chk(r & 32'h1, 32'h1);
        // mixed decay: charge, slow, then fast late in the period
        cyc(1'b1, 8'h00, 32'h18, r);
        cyc(1'b1, 8'h00, 32'h19, r);
        wait_gate(4'h6);
        edge_set(2'h3, 2'h0, 1'b0);
        wait_gate(4'h5);
        wait_gate(4'h9);
        chk({28'h0, gate_b}, 32'h9);
        edge_set(2'h0, 2'h0, 1'b0);
        wait_gate(4'h6);
        summarize();
    end
endmodule
